// ### design/sfb_pkg.sv
// shared constants and types for the flash program and erase sequencer
package sfb_pkg;

    // command opcodes
    localparam logic [7:0] OP_LOAD_B1  = 8'h84; // fill buffer one
    localparam logic [7:0] OP_LOAD_B2  = 8'h87; // fill buffer two
    localparam logic [7:0] OP_PGME_B1  = 8'h83; // buffer one, erase first
    localparam logic [7:0] OP_PGME_B2  = 8'h86; // buffer two, erase first
    localparam logic [7:0] OP_PGM_B1   = 8'h88; // buffer one, no erase
    localparam logic [7:0] OP_PGM_B2   = 8'h89; // buffer two, no erase
    localparam logic [7:0] OP_PG_ERASE = 8'h81; // single page erase
    localparam logic [7:0] OP_BK_ERASE = 8'h50; // eight page erase

    // header is opcode plus three address bytes
    localparam logic [2:0] HDR_BYTES   = 3'h4;
    localparam logic [2:0] LAST_ADDR   = 3'h3;

    // buffer geometry
    localparam int         BUF_DEPTH   = 264;
    localparam logic [8:0] LAST_STD    = 9'h107; // 264 byte page
    localparam logic [8:0] LAST_BIN    = 9'h0FF; // 256 byte page

    // address field positions within the 24 bit address
    localparam int PG_LSB_STD = 9;  // page number field, standard
    localparam int PG_LSB_BIN = 8;  // page number field, binary
    localparam int BK_LSB_STD = 12; // block number field, standard
    localparam int BK_LSB_BIN = 11; // block number field, binary

    // erased flash content and block span
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [2:0] BLOCK_LAST  = 3'h7; // eight pages per block

    // executor states, one-hot
    typedef enum logic [2:0] {
        X_IDLE  = 3'b001,
        X_ERASE = 3'b010,
        X_PROG  = 3'b100
    } sfb_xstate_t;

    // one byte write toward the flash array
    typedef struct packed {
        logic        we;   // write strobe
        logic [11:0] page; // page number
        logic [8:0]  col;  // byte within page
        logic [7:0]  data; // byte value
    } sfb_arr_wr_t;

endpackage : sfb_pkg

// ### design/sfb_seq.sv
// serial flash buffer load, page program and erase sequencer
// Overview of operation
// - opcode 84H/87H loads buffer one/two
// - standard mode: 15 ignored, 9-bit start
// - binary mode: 16 ignored, 8-bit start
// - data bytes stored from start, incrementing
// - pointer wraps to zero past last location
// - storing continues until chip select rises
// - opcode 83H/86H programs with erase first
// - standard: 3 ignored, 12-bit page, 9 ignored
// - binary: 4 ignored, 12-bit page, 8 ignored
// - erase page to ones, then write buffer
// - busy shown during any self-timed operation
// - opcode 88H/89H programs without erase
// - no-erase program writes buffer only
// - opcode 81H erases one page
// - page erase sets addressed page to ones
// - block erase 50H, standard 9-bit block field
// - block erase binary: 4, 9-bit, 11 ignored
// - block erase clears eight consecutive pages
`timescale 1ns/1ps

module sfb_seq #(
    parameter int NUM_PAGES = 4096             // pages in main array
) (
    input  wire logic                clk,      // system clock
    input  wire logic                rstn,     // async reset, low
    input  wire logic                cs_n,     // chip select pin
    input  wire logic                sck,      // serial clock pin
    input  wire logic                si,       // serial data in pin
    input  wire logic                page_256, // binary page size
    output logic                     busy,     // status busy bit
    output sfb_pkg::sfb_arr_wr_t     arr       // array byte write
);
    import sfb_pkg::*;

    // array width is fixed by the 12 bit page field
    if (NUM_PAGES != 4096) begin : g_bad_pages
        $error("sfb_seq: NUM_PAGES must be 4096");
    end

    // reset release synchroniser
    logic [1:0] rst_sync_q;                    // release stages
    wire        rst_n_s = rst_sync_q[1];       // internal reset

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // pin synchronisers, order {mode, si, sck, cs}
    logic [3:0] pin1_q;                        // first stage
    logic [3:0] pin2_q;                        // second stage
    logic [1:0] prev_q;                        // {sck, cs} last cycle

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pin1_q <= 4'h1;
            pin2_q <= 4'h1;
            prev_q <= 2'h1;
        end else begin
            pin1_q <= {page_256, si, sck, cs_n};
            pin2_q <= pin1_q;
            prev_q <= pin2_q[1:0];
        end
    end

    // edge decode on synchronised pins
    wire cs_s     = pin2_q[0];                 // chip select high
    wire si_s     = pin2_q[2];                 // data bit
    wire mode_s   = pin2_q[3];                 // binary page size
    wire sck_rise = pin2_q[1] & ~prev_q[1] & ~cs_s;
    wire cs_rise  = cs_s & ~prev_q[0];

    // byte assembly and header capture
    logic [2:0]  bit_cnt_q;                    // bits in current byte
    logic [7:0]  shreg_q;                      // shift register
    logic [2:0]  byte_cnt_q;                   // header bytes, saturates
    logic [7:0]  opcode_q;                     // captured opcode
    logic [23:0] addr_q;                       // captured address
    logic [8:0]  wptr_q;                       // buffer write pointer

    wire [7:0] new_byte  = {shreg_q[6:0], si_s};
    wire       byte_done = sck_rise & (bit_cnt_q == 3'h7);
    wire       hdr_full  = (byte_cnt_q == HDR_BYTES);
    wire       hdr_last  = byte_done & (byte_cnt_q == LAST_ADDR);

    // opcode classes
    wire is_load  = (opcode_q == OP_LOAD_B1) | (opcode_q == OP_LOAD_B2);
    wire is_pgme  = (opcode_q == OP_PGME_B1) | (opcode_q == OP_PGME_B2);
    wire is_pgm   = (opcode_q == OP_PGM_B1) | (opcode_q == OP_PGM_B2);
    wire is_perase = (opcode_q == OP_PG_ERASE);
    wire is_berase = (opcode_q == OP_BK_ERASE);
    wire buf_two  = (opcode_q == OP_LOAD_B2) | (opcode_q == OP_PGME_B2)
                  | (opcode_q == OP_PGM_B2);

    // start location: low 9 or low 8 bits of the address
    wire [8:0] start_std = {addr_q[0], new_byte};
    wire [8:0] start_bin = {1'b0, new_byte};
    wire [8:0] start_sel = mode_s ? start_bin : start_std;
    wire [8:0] last_s    = mode_s ? LAST_BIN : LAST_STD;
    wire [8:0] start_ok  = (start_sel > last_s) ? 9'h000 : start_sel;

    // data byte into selected buffer while chip select low
    wire       buf_we    = byte_done & hdr_full & is_load;
    wire [8:0] wptr_nxt  = (wptr_q == last_s) ? 9'h000
                         : wptr_q + 9'h001;

    // serial shifter and header bookkeeping
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            bit_cnt_q  <= 3'h0;
            shreg_q    <= 8'h00;
            byte_cnt_q <= 3'h0;
            opcode_q   <= 8'h00;
            addr_q     <= 24'h000000;
            wptr_q     <= 9'h000;
        end else if (cs_s) begin
            // deselected: frame over, restart at next select
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shreg_q   <= new_byte;
            if (byte_done && !hdr_full) begin
                byte_cnt_q <= byte_cnt_q + 3'h1;
                if (byte_cnt_q == 3'h0) begin
                    opcode_q <= new_byte;
                end else begin
                    addr_q <= {addr_q[15:0], new_byte};
                end
            end
            if (hdr_last) begin
                wptr_q <= start_ok;
            end else if (buf_we) begin
                wptr_q <= wptr_nxt;
            end
        end
    end

    // two page buffers, plain storage without reset
    logic [7:0] buf_q [2][BUF_DEPTH];          // buffer contents
    logic [7:0] rd_byte_q;                     // buffer byte read

    always_ff @(posedge clk) begin
        if (buf_we) begin
            buf_q[buf_two][wptr_q] <= new_byte;
        end
    end

    // executor registers
    sfb_xstate_t state_q;                      // executor state
    sfb_xstate_t state_d;                      // next state
    logic [11:0] page_q;                       // page being worked
    logic [2:0]  pcnt_q;                       // pages left after this
    logic [8:0]  col_q;                        // byte within page
    logic        xbuf_q;                       // buffer to program
    logic        then_prog_q;                  // program after erase
    logic        xmode_q;                      // binary size at launch
    logic        busy_q;                       // busy status
    sfb_arr_wr_t arr_q;                        // array write register

    // page and block fields in both address formats
    wire [11:0] page_fld = mode_s
        ? addr_q[PG_LSB_BIN +: 12]
        : addr_q[PG_LSB_STD +: 12];
    wire [8:0]  blk_fld  = mode_s
        ? addr_q[BK_LSB_BIN +: 9]
        : addr_q[BK_LSB_STD +: 9];

    // launch when a full header ends with chip select rising
    wire launch   = cs_rise & hdr_full & (state_q == X_IDLE)
                  & (is_pgme | is_pgm | is_perase | is_berase);
    wire x_last   = col_q == (xmode_q ? LAST_BIN : LAST_STD);
    wire page_end = x_last & (pcnt_q == 3'h0);

    // executor next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            X_IDLE: begin
                if (launch && is_pgm) begin
                    state_d = X_PROG;
                end else if (launch) begin
                    state_d = X_ERASE;
                end
            end
            X_ERASE: begin
                if (page_end && then_prog_q) begin
                    state_d = X_PROG;
                end else if (page_end) begin
                    state_d = X_IDLE;
                end
            end
            X_PROG: begin
                if (x_last) begin
                    state_d = X_IDLE;
                end
            end
            default: begin
                state_d = X_IDLE;
            end
        endcase
    end

    // executor datapath
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_q     <= X_IDLE;
            page_q      <= 12'h000;
            pcnt_q      <= 3'h0;
            col_q       <= 9'h000;
            xbuf_q      <= 1'b0;
            then_prog_q <= 1'b0;
            xmode_q     <= 1'b0;
            busy_q      <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q  <= (state_d != X_IDLE);
            if (launch) begin
                xbuf_q      <= buf_two;
                then_prog_q <= is_pgme;
                xmode_q     <= mode_s;
                col_q       <= 9'h000;
                if (is_berase) begin
                    page_q <= {blk_fld, 3'h0};
                    pcnt_q <= BLOCK_LAST;
                end else begin
                    page_q <= page_fld;
                    pcnt_q <= 3'h0;
                end
            end else if (state_q != X_IDLE) begin
                col_q <= x_last ? 9'h000 : col_q + 9'h001;
                if (x_last && pcnt_q != 3'h0) begin
                    page_q <= page_q + 12'h001;
                    pcnt_q <= pcnt_q - 3'h1;
                end
            end
        end
    end

    // buffer byte fetch for programming, one cycle ahead of write
    always_ff @(posedge clk) begin
        rd_byte_q <= buf_q[xbuf_q][col_q];
    end

    // array write register; data aligns with the fetched byte
    logic       prog_d1_q;                     // program write pending
    logic       erase_d1_q;                    // erase write pending
    logic [11:0] page_d1_q;                    // page of pending write
    logic [8:0]  col_d1_q;                     // column of pending write

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            prog_d1_q  <= 1'b0;
            erase_d1_q <= 1'b0;
            page_d1_q  <= 12'h000;
            col_d1_q   <= 9'h000;
            arr_q      <= '0;
        end else begin
            prog_d1_q  <= (state_q == X_PROG);
            erase_d1_q <= (state_q == X_ERASE);
            page_d1_q  <= page_q;
            col_d1_q   <= col_q;
            arr_q.we   <= prog_d1_q | erase_d1_q;
            arr_q.page <= page_d1_q;
            arr_q.col  <= col_d1_q;
            arr_q.data <= erase_d1_q ? ERASED_BYTE
                                     : rd_byte_q;
        end
    end

    assign busy = busy_q;
    assign arr  = arr_q;

    // checks
    chk_load_gate: assert property (@(posedge clk) disable iff (!rst_n_s)
        buf_we |-> is_load && hdr_full && !cs_s)
        else $error("buffer written outside a load data phase");

    chk_start_std: assert property (@(posedge clk) disable iff (!rst_n_s)
        (hdr_last && !mode_s && start_std <= LAST_STD)
        |=> wptr_q == $past(start_std))
        else $error("standard start location not taken");

    chk_start_bin: assert property (@(posedge clk) disable iff (!rst_n_s)
        (hdr_last && mode_s) |=> wptr_q == $past(start_bin))
        else $error("binary start location not taken");

    chk_ptr_step: assert property (@(posedge clk) disable iff (!rst_n_s)
        (buf_we && wptr_q != last_s) |=> wptr_q == $past(wptr_q) + 9'h001)
        else $error("write pointer did not advance by one");

    chk_ptr_wrap: assert property (@(posedge clk) disable iff (!rst_n_s)
        (buf_we && wptr_q == last_s) |=> wptr_q == 9'h000)
        else $error("write pointer did not wrap to zero");

    chk_launch_busy: assert property (@(posedge clk) disable iff (!rst_n_s)
        launch |=> busy_q ##1 busy_q)
        else $error("busy not shown after launch");

    chk_partial_drop: assert property (@(posedge clk) disable iff (!rst_n_s)
        (cs_rise && !hdr_full && !busy_q) |=> !busy_q)
        else $error("short command started an operation");

    chk_noerase_prog: assert property (@(posedge clk) disable iff (!rst_n_s)
        (launch && is_pgm) |=> state_q == X_PROG)
        else $error("no-erase program did not go straight to write");

    chk_erase_ones: assert property (@(posedge clk) disable iff (!rst_n_s)
        (state_q == X_ERASE) |-> ##2 arr_q.we && arr_q.data == ERASED_BYTE)
        else $error("erase wrote a byte other than all ones");

    chk_block_span: assert property (@(posedge clk) disable iff (!rst_n_s)
        (launch && is_berase) |=> pcnt_q == BLOCK_LAST && page_q[2:0] == 3'h0)
        else $error("block erase did not span eight aligned pages");

    chk_erase_prog: assert property (@(posedge clk) disable iff (!rst_n_s)
        (state_q == X_ERASE && page_end && then_prog_q) |=> state_q == X_PROG)
        else $error("program did not follow auto erase");

endmodule : sfb_seq

// ### verif/sfb_host.sv
// host side serial master model driving chip select, clock and data
`timescale 1ns/1ps

module sfb_host (
    input  wire logic clk,  // bench clock, host moves on falling edge
    output logic      cs_n, // chip select, low only within a frame
    output logic      sck,  // serial clock, stands low between frames
    output logic      si    // serial data toward the device
);
    logic si_bit;   // data bit while selected
    logic idle_pat; // filler while deselected

    // quiet pins at time zero
    initial begin
        cs_n     = 1'b1;
        sck      = 1'b0;
        si_bit   = 1'b0;
        idle_pat = 1'b0;
    end

    // released data line keeps changing so no stale bit looks valid
    always @(negedge clk) begin
        idle_pat <= ~idle_pat;
    end
    assign si = cs_n ? idle_pat : si_bit;

    // one frame: every byte whole, clock 40 ns high and 40 ns low
    task automatic frame(input logic [7:0] q[$]);
        int i;
        int b;
        @(negedge clk);
        cs_n = 1'b0;
        for (i = 0; i < q.size(); i++) begin
            for (b = 7; b >= 0; b--) begin
                si_bit = q[i][b];
                repeat (5) @(negedge clk);
                sck = 1'b1;
                repeat (5) @(negedge clk);
                sck = 1'b0;
            end
        end
        repeat (5) @(negedge clk);
        cs_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : frame
endmodule : sfb_host

// ### verif/sfb_seq_tb.sv
// self-checking bench for the program and erase sequencer
`timescale 1ns/1ps

module sfb_seq_tb;
    import sfb_pkg::*;
    logic        clk;        // 125 MHz clock
    logic        rstn;       // reset, active low
    logic        page_256;   // page size select
    logic        cs_n;       // from host model
    logic        sck;        // from host model
    logic        si;         // from host model
    logic        busy;       // device busy
    sfb_arr_wr_t arr;        // array write port
    int          fail_count; // mismatches
    int          num_checks; // comparisons
    sfb_arr_wr_t exp_q[$];   // expected array writes in order
    logic [7:0]  buf1[264];  // buffer one image
    logic [7:0]  buf2[264];  // buffer two image

    // clock generator
    initial clk = 1'b0;
    always #4 clk = ~clk;

    sfb_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));

    sfb_seq #(.NUM_PAGES(4096)) dut (
        .clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
        .page_256(page_256), .busy(busy), .arr(arr)
    );

    // compare one value and count it
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // verdict and end of run
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // each array write is matched against the oldest note
    always @(posedge clk) begin
        if (arr.we === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected write", 32'h1, 32'h0);
            end else begin
                check("array write", {7'h0, arr}, {7'h0, exp_q.pop_front()});
            end
        end
    end

    // notes for one page: src 0 erased, 1 buffer one, 2 buffer two
    task automatic exp_row(input logic [11:0] pg, input int n, input int src);
        int          c;
        sfb_arr_wr_t w;
        for (c = 0; c < n; c++) begin
            w.we   = 1'b1;
            w.page = pg;
            w.col  = 9'(c);
            w.data = (src == 0) ? ERASED_BYTE : (src == 1) ? buf1[c] : buf2[c];
            exp_q.push_back(w);
        end
    endtask : exp_row

    // address with every ignored bit filled with noise
    function automatic logic [23:0] mk(input logic [23:0] v, input logic [23:0] k);
        return (v & k) | (24'($urandom) & ~k);
    endfunction : mk

    // buffer load from start, wrapping at the page size
    task automatic load(input logic two, input int start, input int n);
        logic [7:0]  q[$];
        logic [23:0] a;
        logic [7:0]  d;
        int          i;
        int          sz;
        sz = page_256 ? 256 : 264;
        a  = mk(24'(start), page_256 ? 24'h0000FF : 24'h0001FF);
        q  = {two ? OP_LOAD_B2 : OP_LOAD_B1, a[23:16], a[15:8], a[7:0]};
        for (i = 0; i < n; i++) begin
            d = 8'($urandom);
            q.push_back(d);
            if (two) buf2[(start + i) % sz] = d;
            else buf1[(start + i) % sz] = d;
        end
        host.frame(q);
    endtask : load

    // self-timed command: busy must rise, fall, all writes seen
    task automatic op(input logic [7:0] code, input logic [23:0] v,
                      input logic [23:0] k);
        logic [7:0]  q[$];
        logic [23:0] a;
        int          t;
        a = mk(v, k);
        q = {code, a[23:16], a[15:8], a[7:0]};
        host.frame(q);
        t = 0;
        while (busy !== 1'b1 && t < 10) begin
            @(negedge clk);
            t++;
        end
        check("busy high", {31'h0, busy}, 32'h1);
        t = 0;
        while (busy !== 1'b0 && t < 20000) begin
            @(negedge clk);
            t++;
        end
        check("busy low", {31'h0, busy}, 32'h0);
        repeat (4) @(negedge clk);
        check("writes left", 32'(exp_q.size()), 32'h0);
    endtask : op

    // main sequence
    initial begin
        logic [7:0] q[$];
        int         k;
        rstn       = 1'b0;
        page_256   = 1'b0;
        fail_count = 0;
        num_checks = 0;
        void'($urandom(89));
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        // short header: no action
        q = {OP_PG_ERASE, 8'h01, 8'h20};
        host.frame(q);
        repeat (10) @(negedge clk);
        check("busy short", {31'h0, busy}, 32'h0);
        // standard pages
        load(1'b0, 260, 264);
        exp_row(12'h5A3, 264, 0);
        exp_row(12'h5A3, 264, 1);
        op(OP_PGME_B1, 24'h5A3 << 9, 24'hFFF << 9);
        exp_row(12'h123, 264, 0);
        op(OP_PG_ERASE, 24'h123 << 9, 24'hFFF << 9);
        exp_row(12'h123, 264, 1);
        op(OP_PGM_B1, 24'h123 << 9, 24'hFFF << 9);
        // binary pages
        page_256 = 1'b1;
        repeat (8) @(negedge clk);
        load(1'b1, 250, 256);
        exp_row(12'hABC, 256, 0);
        exp_row(12'hABC, 256, 2);
        op(OP_PGME_B2, 24'hABC << 8, 24'hFFF << 8);
        for (k = 0; k < 8; k++) exp_row(12'(4088 + k), 256, 0);
        op(OP_BK_ERASE, 24'h1FF << 11, 24'h1FF << 11);
        exp_row(12'd4090, 256, 2);
        op(OP_PGM_B2, 24'd4090 << 8, 24'hFFF << 8);
        // standard block erase
        page_256 = 1'b0;
        repeat (8) @(negedge clk);
        for (k = 0; k < 8; k++) exp_row(12'(24 + k), 264, 0);
        op(OP_BK_ERASE, 24'h3 << 12, 24'h1FF << 12);
        print_verdict();
    end

    // watchdog against a hang
    initial begin
        #1_000_000;
        fail_count++;
        print_verdict();
    end
endmodule : sfb_seq_tb
